/* File: src/arm_regs.vh */
// Register layout and field encodings for the region attribute unit
`ifndef ARM_REGS_VH
`define ARM_REGS_VH
`define ARM_SEL_R0 1'h0
`define ARM_SEL_R1 1'h1
`define ARM_BASE_HI 31
`define ARM_BASE_LO 24
`define ARM_MASK_HI 23
`define ARM_MASK_LO 16
`define ARM_EN_BIT 15
`define ARM_PRIV_HI 14
`define ARM_PRIV_LO 13
`define ARM_CI_BIT 6
`define ARM_BW_BIT 5
`define ARM_WP_BIT 2
`define ARM_WR_MASK 32'hFFFF_E064
`define ARM_RESET_VAL 32'h0000_0000
`define ARM_PRIV_USER 2'h0
`define ARM_PRIV_SUPV 2'h1
`endif

/* File: src/arm_region_match.v */
// One region register compare: address, privilege and enable
`timescale 1ns/1ns
module arm_region_match (
	input wire [31:0] region_reg,
	input wire [7:0] addr_hi,
	input wire supervisor,
	output wire hit
);
`include "arm_regs.vh"
	wire [7:0] base = region_reg[`ARM_BASE_HI:`ARM_BASE_LO];
	wire [7:0] mask = region_reg[`ARM_MASK_HI:`ARM_MASK_LO];
	wire [1:0] priv = region_reg[`ARM_PRIV_HI:`ARM_PRIV_LO];
	// Masked bits drop out of the compare
	wire addr_ok = ((addr_hi ^ base) & ~mask) == 8'h00;
	wire priv_ok = priv[1] ? 1'b1 :
		(priv == `ARM_PRIV_SUPV) ? supervisor : ~supervisor;
	assign hit = region_reg[`ARM_EN_BIT] & addr_ok & priv_ok;
endmodule

/* File: src/arm_attr_unit.v */
// Region attribute unit: two region registers, attribute select, write termination
//
// What this block does
// - Privilege select 00 user only, 01 supervisor only, 1x any mode.
// - Cache inhibit bit 0 cacheable, 1 noncacheable for matching references.
// - Buffered bit 0: local write ends only after external cycle completes.
// - Buffered bit 1: write with ext_ready sets wbuf_busy, but still ends only after external cycle completes.
// - Write access errors are imprecise, buffered ones reported at the same point as unbuffered ones.
// - Write-protected region ends writes with access error; reads proceed.
// - Match when address 31:24 equals base, masked bits ignored.
// - Enable bit per region, cleared by reset; disabled region never matches.
// - Regions checked only for references outside flash and SRAM.
// - No enabled match: use default attributes from cache control register.
`timescale 1ns/1ns
module arm_attr_unit (
	input wire ref_clk,
	input wire rst,
	input wire reg_wr,
	input wire reg_sel,
	input wire [31:0] reg_wdata,
	input wire dbg_sel,
	output reg [31:0] dbg_rdata,
	input wire dflt_cache_inhibit,
	input wire dflt_buffered,
	input wire dflt_write_protect,
	input wire ref_valid,
	input wire [31:0] ref_addr,
	input wire ref_write,
	input wire ref_supervisor,
	input wire ref_onchip,
	output wire ref_ready,
	output reg attr_cache_inhibit,
	output reg attr_buffered,
	output reg attr_write_protect,
	output reg attr_region_hit,
	output wire ext_req,
	input wire ext_ready,
	input wire ext_done,
	input wire ext_error,
	output reg acc_error,
	output reg wbuf_busy
);
`include "arm_regs.vh"
	// States: idle, waiting on external completion, buffered write in flight
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_BUF = 2'h2;
	reg [31:0] region0_r;
	reg [31:0] region1_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	wire hit0;
	wire hit1;
	reg sel_ci;
	reg sel_bw;
	reg sel_wp;
	reg sel_hit;
	// Write-only from software; reserved bits forced to zero on store
	wire wr0 = reg_wr && (reg_sel == `ARM_SEL_R0);
	wire wr1 = reg_wr && (reg_sel == `ARM_SEL_R1);
	wire [31:0] wr_val = reg_wdata & `ARM_WR_MASK;
	always @(posedge ref_clk) begin
		if (rst) begin
			region0_r <= `ARM_RESET_VAL;
		end else if (wr0) begin
			region0_r <= wr_val;
		end
	end
	always @(posedge ref_clk) begin
		if (rst) begin
			region1_r <= `ARM_RESET_VAL;
		end else if (wr1) begin
			region1_r <= wr_val;
		end
	end
	// Readback for the debug port only; the core cannot read these
	reg [31:0] dbg_nxt;
	always @* begin
		case (dbg_sel)
			`ARM_SEL_R0: begin
				dbg_nxt = region0_r;
			end
			default: begin
				dbg_nxt = region1_r;
			end
		endcase
	end
	always @(posedge ref_clk) begin
		if (rst) begin
			dbg_rdata <= 32'h0000_0000;
		end else begin
			dbg_rdata <= dbg_nxt;
		end
	end
	// Both regions compared in parallel every cycle
	arm_region_match u_match0 (
		.region_reg(region0_r),
		.addr_hi(ref_addr[31:24]),
		.supervisor(ref_supervisor),
		.hit(hit0)
	);
	arm_region_match u_match1 (
		.region_reg(region1_r),
		.addr_hi(ref_addr[31:24]),
		.supervisor(ref_supervisor),
		.hit(hit1)
	);
	// Per-region attribute fields, pulled out once so the priority mux stays flat
	wire r0_ci = region0_r[`ARM_CI_BIT];
	wire r0_bw = region0_r[`ARM_BW_BIT];
	wire r0_wp = region0_r[`ARM_WP_BIT];
	wire r1_ci = region1_r[`ARM_CI_BIT];
	wire r1_bw = region1_r[`ARM_BW_BIT];
	wire r1_wp = region1_r[`ARM_WP_BIT];
	// On-chip references never look at the regions
	wire use0 = !ref_onchip && hit0;
	wire use1 = !ref_onchip && hit1 && !hit0;
	always @* begin
		sel_hit = 1'b0;
		sel_ci = dflt_cache_inhibit;
		sel_bw = dflt_buffered;
		sel_wp = dflt_write_protect;
		case ({use1, use0})
			2'h1: begin
				sel_hit = 1'b1;
				sel_ci = r0_ci;
				sel_bw = r0_bw;
				sel_wp = r0_wp;
			end
			2'h2: begin
				sel_hit = 1'b1;
				sel_ci = r1_ci;
				sel_bw = r1_bw;
				sel_wp = r1_wp;
			end
			default: begin
				sel_hit = 1'b0;
			end
		endcase
	end
	// Attributes registered so the far side sees stable values
	wire take_any = ref_valid && ref_ready;
	always @(posedge ref_clk) begin
		if (rst) begin
			attr_cache_inhibit <= 1'b0;
			attr_buffered <= 1'b0;
			attr_write_protect <= 1'b0;
			attr_region_hit <= 1'b0;
		end else if (take_any) begin
			attr_cache_inhibit <= sel_ci;
			attr_buffered <= sel_bw;
			attr_write_protect <= sel_wp;
			attr_region_hit <= sel_hit;
		end
	end
	wire take = take_any && !ref_onchip;
	// Faulting write: no external cycle, error flag next cycle
	wire wp_fault = take && ref_write && sel_wp;
	wire start_ext = take && !wp_fault;
	// One outstanding external cycle; new references stall meanwhile
	assign ref_ready = (state_r == ST_IDLE);
	assign ext_req = start_ext;
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_ext && !ext_ready) begin
					state_nxt = ST_WAIT;
				end else if (start_ext && ref_write && sel_bw) begin
					state_nxt = ST_BUF;
				end else if (start_ext && ref_write) begin
					state_nxt = ST_WAIT;
				end else if (start_ext) begin
					// Reads wait too, keeping a single outstanding external cycle
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (ext_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_BUF: begin
				if (ext_done) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	always @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// Errors on writes are reported imprecisely: one cycle after cause, never tied to the
	// instruction; external ones only when the cycle finishes, whether buffered or not
	wire ext_fault = ext_done && ext_error && (state_r != ST_IDLE);
	wire err_nxt = wp_fault || ext_fault;
	wire busy_nxt = (state_nxt == ST_BUF);
	always @(posedge ref_clk) begin
		if (rst) begin
			acc_error <= 1'b0;
		end else begin
			acc_error <= err_nxt;
		end
	end
	always @(posedge ref_clk) begin
		if (rst) begin
			wbuf_busy <= 1'b0;
		end else begin
			wbuf_busy <= busy_nxt;
		end
	end
endmodule

/* File: testbench/arm_ext_model.sv */
// External bus side: completes each started cycle after a chosen latency
`timescale 1ns/1ns
module arm_ext_model(input wire ref_clk, input wire rst, input wire ext_req,
	input wire [3:0] lat, output reg ext_done, output wire ext_error);
	reg [3:0] cnt_r;
	reg busy_r;
	assign ext_error = 1'h0;
	// One cycle at a time, as the unit keeps one outstanding
	always @(posedge ref_clk) begin
		ext_done <= 1'h0;
		if (rst)
			busy_r <= 1'h0;
		else if (ext_req && !busy_r) begin
			busy_r <= 1'h1;
			cnt_r <= lat;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 4'h1;
			if (cnt_r == 4'h0) begin
				ext_done <= 1'h1;
				busy_r <= 1'h0;
			end
		end
	end
endmodule

/* File: testbench/arm_attr_unit_asserts.sv */
// Port checks of the region attribute unit
`timescale 1ns/1ns
module arm_attr_asserts(input wire ref_clk, input wire rst, input wire ref_valid,
	input wire ref_ready, input wire ref_write, input wire ref_onchip, input wire ext_req,
	input wire ext_ready, input wire ext_done, input wire acc_error, input wire wbuf_busy,
	input wire attr_buffered, input wire attr_region_hit, input wire attr_cache_inhibit,
	input wire attr_write_protect, input wire dflt_cache_inhibit);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire tk = ref_valid && ref_ready;
	sequence wtk;
		ext_req && ref_write && ext_ready;
	endsequence
	prot_err_a: assert property (acc_error |-> attr_write_protect && $past(ref_write) && !$past(ext_req)) else $error("bad error");
	chip_noreq_a: assert property (tk && ref_onchip |-> !ext_req) else $error("onchip req");
	chip_nohit_a: assert property (tk && ref_onchip |=> !attr_region_hit) else $error("onchip hit");
	req_src_a: assert property (ext_req |-> tk && !ref_onchip) else $error("stray req");
	nobuf_wait_a: assert property (wtk |=> (!attr_buffered |-> !ref_ready && !wbuf_busy)) else $error("no stall");
	buf_busy_a: assert property (wtk |=> (attr_buffered |-> wbuf_busy)) else $error("not buffered");
	dflt_ci_a: assert property ($past(tk) && !attr_region_hit |-> attr_cache_inhibit == $past(dflt_cache_inhibit)) else $error("bad default");
	done_rel_a: assert property (ext_done && !ref_ready |=> ref_ready) else $error("no release");
endmodule
bind arm_attr_unit arm_attr_asserts u_arm_attr_asserts(.*);

/* File: testbench/arm_attr_unit_tb.sv */
// Self-checking bench of the region attribute unit
`timescale 1ns/1ns
`include "arm_regs.vh"
module arm_attr_unit_tb;
	reg ref_clk = 0, rst = 1, reg_wr = 0, reg_sel = 0, dbg_sel = 0, ref_valid = 0, ref_write = 0;
	reg dflt_cache_inhibit = 0, dflt_buffered = 0, dflt_write_protect = 0;
	reg ref_supervisor = 0, ref_onchip = 0, ext_ready = 0, tk = 0;
	reg [31:0] reg_wdata = 0, ref_addr = 0;
	reg [3:0] lat = 0;
	wire [31:0] dbg_rdata;
	wire ref_ready, attr_cache_inhibit, attr_buffered, attr_write_protect, attr_region_hit;
	wire ext_req, ext_done, ext_error, acc_error, wbuf_busy;
	reg [31:0] rg [0:1];
	reg [5:0] q [$];
	int error_cnt = 0, comparisons = 0;
	arm_attr_unit u_arm_attr_unit(.*);
	arm_ext_model u_arm_ext_model(.*);
	initial forever #5 ref_clk = ~ref_clk;
	function [3:0] ex(input [31:0] a, input s, input o);
		reg [31:0] r;
		ex = {1'h0, dflt_cache_inhibit, dflt_buffered, dflt_write_protect};
		// Second region first, so the first one overrides on a double hit
		for (int i = 1; i >= 0; i--) begin
			r = rg[i];
			if (!o && r[15] && ((r[31:24] ^ a[31:24]) & ~r[23:16]) == 8'h00 && (r[14] || r[13] == s))
				ex = {1'h1, r[6], r[5], r[2]};
		end
	endfunction
	task chk(input [31:0] v, input [31:0] e);
		comparisons++;
		if (v !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	task summarize;
		if (error_cnt == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wr(input s, input [31:0] d);
		reg_wr <= 1; reg_sel <= s; reg_wdata <= d;
		rg[s] = d & `ARM_WR_MASK;
		@(posedge ref_clk) reg_wr <= 0;
		@(posedge ref_clk);
	endtask
	task rq(input [31:0] a, input w, input s, input o, input er);
		int n;
		reg [3:0] e;
		ref_valid <= 1; ref_addr <= a; ref_write <= w; ref_supervisor <= s; ref_onchip <= o;
		ext_ready <= er; lat <= $urandom % 4;
		e = ex(a, s, o);
		q.push_back({!o && w && e[0], !o && w && !e[0] && e[1] && er, e});
		n = 0;
		@(negedge ref_clk);
		while (ref_ready !== 1'h1) begin
			@(negedge ref_clk) n++;
			if (n > 60) begin error_cnt++; summarize; end
		end
		@(posedge ref_clk);
	endtask
	always @(posedge ref_clk) tk <= ref_valid && ref_ready;
	always @(negedge ref_clk) if (tk)
		chk({acc_error, wbuf_busy, attr_region_hit, attr_cache_inhibit, attr_buffered,
			attr_write_protect}, q.pop_front());
	initial begin
		reg [31:0] a, d;
		void'($urandom(32'h2B0B4FCD));
		rg[0] = 0; rg[1] = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 0;
		for (int i = 0; i < 5; i++) begin
			for (int s = 0; s < 2; s++) begin
				dbg_sel <= s;
				@(posedge ref_clk);
				@(negedge ref_clk) chk(dbg_rdata, rg[s]);
				@(posedge ref_clk);
			end
			d = $urandom; d[31:20] = 12'h400; d[15] = i > 0; d[14:13] = i[1:0];
			wr(0, d);
			d = $urandom; d[31:17] = 15'h2080;
			wr(1, d);
			{dflt_cache_inhibit, dflt_buffered, dflt_write_protect} <= $urandom;
			@(posedge ref_clk);
			repeat (20) begin
				a = $urandom;
				if (a[0]) a[31:28] = 4'h4;
				rq(a, a[1], a[2], a[3] & a[4], a[5]);
			end
			ref_valid <= 0;
		end
		repeat (20) @(posedge ref_clk);
		summarize;
	end
endmodule
